// ===== rtl/swmon_pkg.sv
// Notes on behaviour
// [R1] pulse mode: wetting on closed switches for 20ms after debounce
// [R2] wetting mode bit 15 set: continuous wetting on enabled closed switches
// [R3] any valid change starts a wetting pulse on all closed switches
// [R4] one shared wetting timer, restarted by every valid change
// [R5] scan mode: wetting only in poll window; pulse mode stops after 20ms
// [R6] reset clears the whole configuration word to zero
// [R7] direct outputs copy inputs 0/1 only with in01 enable low, normal mode
// [R8] direct inputs 0/1 neither update state bits nor raise interrupts
// [R9] open-drain interrupt pulls low on unmasked debounced input change
// [R10] first watchdog timeout also asserts the interrupt
// [R11] chip-select falling edge releases interrupt and over-temperature pins
// [R12] over-temperature pin asserts on warning crossing, cleared by select fall
// [R13] status bit 7 follows temperature with hysteresis, spi never clears it
// [R14] thermal warning turns off wetting until temperature drops back
// [R15] select fall loads status word, shifted out msb first on rising clock
// [R16] data input sampled on falling serial clock while selected
// [R17] select rise copies shift register into configuration word
// [R18] master gives exactly sixteen clocks per select low period
// [R19] deselected: data output high impedance, clock and data ignored
// [R20] input changes during a transfer still assert the interrupt
// [R21] status: inputs 7..0 in bits 15..8, one closed, bit 7 over-temp
// [R22] config: mode 15, scan 14..12, wen 11, in01 10, polarity 9..8, masks
// [R23] scan mode: all sense resistors on for 250us once per period; inputs 0/1 stay off while in01 enable is low
// [R24] codes 111/110 normal mode; 000..101 scan 64 down to 2 ms
// [R25] inputs 0/1 wetting needs both global and in01 enables
// [R26] polarity bits 9 and 8 select battery sensing for 7/6 and 5/4
// [R27] unused status bits 6..0 read as zero
// [R28] frame without exactly sixteen clocks leaves configuration unchanged
package swmon_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_MHZ       = 25;
	localparam int unsigned WET_PULSE_US  = 20000;
	localparam int unsigned WET_PULSE_CYC = WET_PULSE_US * CLK_MHZ;
	localparam int unsigned POLL_US       = 250;
	localparam int unsigned POLL_CYC      = POLL_US * CLK_MHZ;
	localparam int unsigned SCAN_BASE_US  = 2000;
	localparam int unsigned SCAN_BASE_CYC = SCAN_BASE_US * CLK_MHZ;

	// ---------------------------------------------------------------
	// word layouts
	// ---------------------------------------------------------------
	localparam int unsigned WORD_W       = 16;
	localparam int unsigned CFG_WET_CONT = 15;
	localparam int unsigned CFG_SCAN_HI  = 14;
	localparam int unsigned CFG_SCAN_LO  = 12;
	localparam int unsigned CFG_WEN      = 11;
	localparam int unsigned CFG_IN01_WET = 10;
	localparam int unsigned CFG_POL_UP   = 9;
	localparam int unsigned CFG_POL_LO   = 8;
	localparam int unsigned CFG_MASK_HI  = 7;
	localparam int unsigned STS_OVERTEMP = 7;
	localparam logic [15:0] CFG_RESET    = 16'h0000;
	localparam logic [2:0]  SCAN_CONT    = 3'h7;
	localparam logic [2:0]  SCAN_NOHYS   = 3'h6;
	localparam logic [2:0]  SCAN_MAXCODE = 3'h5;
	localparam logic [4:0]  FRAME_BITS   = 5'h10;

endpackage

// ===== rtl/spi_link_if.sv
`timescale 1ns/100ps
// carries the shifter's frame events and words to the core
interface spi_link_if;
	logic [15:0] status_word;
	logic [15:0] cfg_word;
	logic        cfg_load;
	logic        cs_fall;
	logic        cs_low;

	modport shifter (input status_word, output cfg_word, output cfg_load,
		output cs_fall, output cs_low);
	modport core (output status_word, input cfg_word, input cfg_load,
		input cs_fall, input cs_low);
endinterface

// ===== rtl/sync_pipe.sv
`timescale 1ns/100ps
// two-flop synchroniser; first stage feeds only the second
module sync_pipe #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	// ---------------------------------------------------------------
	// stages
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_r <= '0;
			q_o    <= '0;
		end
		else
		begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule // sync_pipe

// ===== rtl/spi_slave_port.sv
`timescale 1ns/100ps
// serial shifter, inputs already synchronised to clk_i
module spi_slave_port (
	input  wire logic     clk_i,
	input  wire logic     rst_i,
	input  wire logic     cs_n_s_i,
	input  wire logic     sclk_s_i,
	input  wire logic     sdi_s_i,
	output logic          sdo_o,
	output logic          sdo_oe_o,
	spi_link_if.shifter   link
);
	logic        cs_n_d_r;
	logic        sclk_d_r;
	logic [15:0] sh_r;
	logic [4:0]  cnt_r;
	logic        cs_fall;
	logic        cs_rise;
	logic        sclk_rise;
	logic        sclk_fall;

	// ---------------------------------------------------------------
	// edge decode; clock edges only count while selected
	// ---------------------------------------------------------------
	assign cs_fall   = cs_n_d_r & ~cs_n_s_i;
	assign cs_rise   = ~cs_n_d_r & cs_n_s_i;
	assign sclk_rise = ~sclk_d_r & sclk_s_i & ~cs_n_s_i;  // R19
	assign sclk_fall = sclk_d_r & ~sclk_s_i & ~cs_n_s_i;  // R19

	assign link.cs_fall  = cs_fall;
	assign link.cs_low   = ~cs_n_s_i;
	assign link.cfg_word = sh_r;
	// short or long frames are dropped
	assign link.cfg_load = cs_rise & (cnt_r == swmon_pkg::FRAME_BITS); // R17 R28
	assign sdo_oe_o      = ~cs_n_s_i;  // R19

	// ---------------------------------------------------------------
	// shift register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cs_n_d_r <= 1'b1;
			sclk_d_r <= 1'b0;
			sh_r     <= 16'h0000;
			cnt_r    <= 5'h00;
			sdo_o    <= 1'b0;
		end
		else
		begin
			cs_n_d_r <= cs_n_s_i;
			sclk_d_r <= sclk_s_i;
			if (cs_fall)
			begin
				sh_r  <= link.status_word;  // R15
				cnt_r <= 5'h00;
				sdo_o <= link.status_word[15];
			end
			else if (sclk_fall)
			begin
				sh_r <= {sh_r[14:0], sdi_s_i};  // R16
				if (cnt_r != 5'h1f)
					cnt_r <= cnt_r + 5'h01;  // saturates, never wraps to 16
			end
			else if (sclk_rise)
				sdo_o <= sh_r[15];  // R15
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_short_frame: assert property (@(posedge clk_i) disable iff (rst_i) // R28
		(cs_rise && cnt_r != swmon_pkg::FRAME_BITS) |-> !link.cfg_load)
		else $error("partial frame loaded configuration");
	a_idle_hiz: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		cs_n_s_i |-> (!sdo_oe_o && $stable(sh_r)))
		else $error("shifter active while deselected");
	c_full_frame: cover property (@(posedge clk_i) disable iff (rst_i)
		link.cfg_load);
endmodule // spi_slave_port

// ===== rtl/switch_monitor_spi_core.sv
`timescale 1ns/100ps
module switch_monitor_spi_core #(
	parameter int unsigned WET_CYC  = swmon_pkg::WET_PULSE_CYC,
	parameter int unsigned POLL_CYC = swmon_pkg::POLL_CYC,
	parameter int unsigned BASE_CYC = swmon_pkg::SCAN_BASE_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       chip_select_n_i,
	input  wire logic       serial_clk_i,
	input  wire logic       serial_data_i,
	output logic            serial_data_o,
	output logic            serial_data_oe_o,
	input  wire logic [7:0] switch_input_i,
	input  wire logic       temp_warn_i,
	input  wire logic       temp_clear_i,
	input  wire logic       watchdog_first_timeout_i,
	output logic            irq_n_o,
	output logic            irq_n_oe_o,
	output logic            overtemp_n_o,
	output logic            overtemp_n_oe_o,
	output logic            direct_level_out0_o,
	output logic            direct_level_out0_oe_o,
	output logic            direct_level_out1_o,
	output logic            direct_level_out1_oe_o,
	output logic [7:0]      wetting_drive_o,
	output logic [7:0]      sense_connect_o,
	output logic            polarity_upper_pair_o,
	output logic            polarity_lower_pair_o,
	output logic            hyst_adjust_en_o
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	spi_link_if link ();

	logic [2:0]  spi_s;
	logic [7:0]  sw_s;
	logic [2:0]  misc_s;
	logic        temp_warn_s;
	logic        temp_clear_s;
	logic        wd_s;

	logic [15:0] cfg_r;
	logic [7:0]  sw_state_r;
	logic [7:0]  sw_state_nxt;
	logic        wd_d_r;
	logic        irq_pend_r;
	logic        hot_state_r;
	logic        hot_pin_r;
	logic [31:0] wet_cnt_r;
	logic [31:0] scan_cnt_r;
	logic [31:0] scan_cnt_nxt;
	logic [7:0]  wet_r;
	logic [7:0]  wet_nxt;
	logic [7:0]  sense_r;
	logic [7:0]  sense_nxt;
	logic [1:0]  do_r;
	logic        do_oe_r;

	logic        wet_cont;
	logic [2:0]  scan_code;
	logic        wen;
	logic        in01_wet_en;
	logic [7:0]  irq_mask;
	logic        normal_mode;
	logic [7:0]  track;
	logic [7:0]  chg;
	logic        irq_evt;
	logic        wd_evt;
	logic        hot_set;
	logic        wet_run;
	logic [31:0] scan_period;
	logic        scan_wrap;
	logic        poll_win;
	logic        wet_phase;
	logic [7:0]  wet_allow;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	sync_pipe #(.W(3)) u_spi_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({~chip_select_n_i, serial_clk_i, serial_data_i}),
		.q_o   (spi_s)
	);

	sync_pipe #(.W(8)) u_sw_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (switch_input_i),
		.q_o   (sw_s)
	);

	sync_pipe #(.W(3)) u_misc_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({temp_warn_i, temp_clear_i, watchdog_first_timeout_i}),
		.q_o   (misc_s)
	);

	assign temp_warn_s  = misc_s[2];
	assign temp_clear_s = misc_s[1];
	assign wd_s         = misc_s[0];

	// ---------------------------------------------------------------
	// serial port
	// ---------------------------------------------------------------
	spi_slave_port u_spi (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.cs_n_s_i (~spi_s[2]),  // flop reset 0 reads as deselected
		.sclk_s_i (spi_s[1]),
		.sdi_s_i  (spi_s[0]),
		.sdo_o    (serial_data_o),
		.sdo_oe_o (serial_data_oe_o),
		.link     (link.shifter)
	);

	// status word, unused bits forced low
	assign link.status_word = {sw_state_r, hot_state_r, 7'h00}; // R21 R27

	// ---------------------------------------------------------------
	// configuration fields
	// ---------------------------------------------------------------
	assign wet_cont  = cfg_r[swmon_pkg::CFG_WET_CONT];  // R22
	assign scan_code = cfg_r[swmon_pkg::CFG_SCAN_HI:swmon_pkg::CFG_SCAN_LO];
	assign wen       = cfg_r[swmon_pkg::CFG_WEN];
	assign in01_wet_en = cfg_r[swmon_pkg::CFG_IN01_WET];
	assign irq_mask  = cfg_r[swmon_pkg::CFG_MASK_HI:0];

	// codes 110 and 111 run continuously
	assign normal_mode = (scan_code == swmon_pkg::SCAN_CONT) ||
		(scan_code == swmon_pkg::SCAN_NOHYS);  // R24

	assign polarity_upper_pair_o = cfg_r[swmon_pkg::CFG_POL_UP];  // R26
	assign polarity_lower_pair_o = cfg_r[swmon_pkg::CFG_POL_LO];  // R26
	assign hyst_adjust_en_o      = (scan_code != swmon_pkg::SCAN_NOHYS);

	// configuration register, only full frames land here
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cfg_r <= swmon_pkg::CFG_RESET;  // R6
		else if (link.cfg_load)
			cfg_r <= link.cfg_word;  // R17
	end

	// ---------------------------------------------------------------
	// switch state and change events
	// ---------------------------------------------------------------
	// inputs 0/1 are not tracked while acting as direct inputs
	assign track        = {6'h3f, in01_wet_en, in01_wet_en};  // R8
	assign chg          = (sw_s ^ sw_state_r) & track;
	assign sw_state_nxt = (sw_s & track) | (sw_state_r & ~track);
	assign irq_evt      = |(chg & ~irq_mask);  // R9 R20
	assign wd_evt       = wd_s & ~wd_d_r;  // R10
	assign hot_set      = temp_warn_s & ~hot_state_r;  // R12

	// event flags: a set in the select-fall cycle wins over the release
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sw_state_r <= 8'h00;
			wd_d_r     <= 1'b0;
			irq_pend_r <= 1'b0;
			hot_pin_r   <= 1'b0;
			hot_state_r <= 1'b0;
		end
		else
		begin
			sw_state_r <= sw_state_nxt;  // R8
			wd_d_r     <= wd_s;
			if (irq_evt || wd_evt)
				irq_pend_r <= 1'b1;  // R9 R10 R20
			else if (link.cs_fall)
				irq_pend_r <= 1'b0;  // R11
			if (hot_set)
				hot_pin_r <= 1'b1;  // R12
			else if (link.cs_fall)
				hot_pin_r <= 1'b0;  // R11 R12
			if (temp_warn_s)
				hot_state_r <= 1'b1;  // R13
			else if (temp_clear_s)
				hot_state_r <= 1'b0;  // R13
		end
	end

	// open-drain pins: drive low when enabled
	assign irq_n_o         = 1'b0;
	assign irq_n_oe_o      = irq_pend_r;
	assign overtemp_n_o    = 1'b0;
	assign overtemp_n_oe_o = hot_pin_r;

	// ---------------------------------------------------------------
	// shared wetting timer
	// ---------------------------------------------------------------
	// one timer for all inputs, so close closures stretch the pulse
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wet_cnt_r <= 32'h0000_0000;
		else if (|chg)
			wet_cnt_r <= WET_CYC;  // R3 R4
		else if (wet_cnt_r != 32'h0000_0000)
			wet_cnt_r <= wet_cnt_r - 32'h0000_0001;  // R1
	end

	assign wet_run = (wet_cnt_r != 32'h0000_0000);

	// ---------------------------------------------------------------
	// scan poll timer
	// ---------------------------------------------------------------
	// period halves per code step from 64 ms at code 000
	assign scan_period = BASE_CYC << (swmon_pkg::SCAN_MAXCODE - scan_code);
	assign scan_wrap   = (scan_cnt_r >= scan_period - 32'h0000_0001);
	assign poll_win    = !normal_mode && (scan_cnt_r < POLL_CYC);  // R23

	always_comb
	begin
		if (normal_mode || scan_wrap)
			scan_cnt_nxt = 32'h0000_0000;  // R23 R24
		else
			scan_cnt_nxt = scan_cnt_r + 32'h0000_0001;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			scan_cnt_r <= 32'h0000_0000;
		else
			scan_cnt_r <= scan_cnt_nxt;
	end

	// ---------------------------------------------------------------
	// wetting and sense drive
	// ---------------------------------------------------------------
	// thermal cut applies only to wetting; sensing continues
	assign wet_allow = {{6{wen}}, {2{wen & in01_wet_en}}} &
		{8{~hot_state_r}};  // R14 R25
	assign wet_phase = (wet_cont || wet_run) &&
		(normal_mode || poll_win);  // R1 R2 R5
	assign wet_nxt   = sw_state_r & wet_allow & {8{wet_phase}};  // R2 R3
	assign sense_nxt = {8{normal_mode || poll_win}} & track;  // R23

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wet_r   <= 8'h00;
			sense_r <= 8'h00;
		end
		else
		begin
			wet_r   <= wet_nxt;
			sense_r <= sense_nxt;
		end
	end

	assign wetting_drive_o = wet_r;
	assign sense_connect_o = sense_r;

	// ---------------------------------------------------------------
	// direct level outputs
	// ---------------------------------------------------------------
	// adds the synchroniser delay; fine for slow pwm, not for fast edges
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			do_r    <= 2'h0;
			do_oe_r <= 1'b0;
		end
		else
		begin
			do_r    <= sw_s[1:0];  // R7
			do_oe_r <= !in01_wet_en && normal_mode;  // R7
		end
	end

	assign direct_level_out0_o    = do_r[0];
	assign direct_level_out1_o    = do_r[1];
	assign direct_level_out0_oe_o = do_oe_r;
	assign direct_level_out1_oe_o = do_oe_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_cfg_reset: assert property (disable iff (1'b0) // R6
		rst_i |=> (cfg_r == swmon_pkg::CFG_RESET))
		else $error("configuration not cleared by reset");
	a_irq_on_change: assert property ( // R9
		irq_evt |=> irq_n_oe_o)
		else $error("unmasked change did not assert interrupt");
	a_irq_release: assert property ( // R11
		(link.cs_fall && !irq_evt && !wd_evt) |=> !irq_n_oe_o)
		else $error("interrupt not released by select fall");
	a_irq_in_frame: assert property ( // R20
		(irq_evt && link.cs_low) |=> irq_n_oe_o)
		else $error("change during transfer did not interrupt");
	a_temp_release: assert property ( // R12
		(link.cs_fall && !hot_set) |=> (!overtemp_n_oe_o &&
		($stable(hot_state_r) || temp_clear_s || temp_warn_s)))
		else $error("over-temperature pin not released");
	a_temp_status: assert property ( // R13
		(hot_state_r && !temp_clear_s) |=> hot_state_r)
		else $error("status over-temperature cleared early");
	a_direct_hold: assert property ( // R8
		!in01_wet_en |=> (sw_state_r[1:0] == $past(sw_state_r[1:0])))
		else $error("direct input changed its state bits");
	a_direct_oe: assert property ( // R7
		(in01_wet_en || !normal_mode) |=> !direct_level_out0_oe_o)
		else $error("direct output driven out of mode");
	a_wet_restart: assert property ( // R4
		(|chg) |=> (wet_cnt_r == WET_CYC))
		else $error("wetting timer not restarted");
	a_wet_thermal: assert property ( // R14
		hot_state_r |=> (wetting_drive_o == 8'h00))
		else $error("wetting active during thermal warning");
	a_wet_scan: assert property ( // R5
		(!normal_mode && !poll_win) ##1 !normal_mode
		|-> (wetting_drive_o == 8'h00))
		else $error("scan wetting outside poll window");
	a_status_low: assert property ( // R27
		link.status_word[6:0] == 7'h00)
		else $error("unused status bits not zero");

	c_irq_seen: cover property (irq_evt ##1 irq_n_oe_o);
	c_wet_expire: cover property (wet_run ##1 !wet_run);
	c_poll_open: cover property (!poll_win ##1 poll_win);
	c_temp_cycle: cover property (hot_set ##[1:50] link.cs_fall);
endmodule // switch_monitor_spi_core

// ===== sim/spi_master_model.sv
`timescale 1ns/100ps
// -------------------------------------------------
// spi master partner, cpol0, 320 ns link clock
// -------------------------------------------------
module spi_master_model (
	input  wire logic        clk_i,
	output logic             cs_n_o,
	output logic             sclk_o,
	output logic             mosi_o,
	input  wire logic        miso_i,
	output logic [15:0]      rd_o,
	output logic             done_o
);
	// idle: deselected, clock standing low
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
		rd_o   = 16'h0000;
		done_o = 1'b0;
	end

	// one frame; fewer than 16 clocks only to provoke a refusal
	task automatic xfer(input logic [15:0] wr, input int nbits);
		logic [15:0] rd;
		rd = 16'h0000;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		for (int i = 15; i > 15 - nbits; i--)
		begin
			mosi_o <= wr[i];
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			rd = {rd[14:0], miso_i};  // bit settled since the rise
			sclk_o <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
		cs_n_o <= 1'b1;
		mosi_o <= ~mosi_o;  // released line must not show a stale bit
		rd_o   <= rd;
		done_o <= (nbits == 16);
		@(posedge clk_i);
		done_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
endmodule // spi_master_model

// ===== sim/test_switch_monitor_spi_core.sv
`timescale 1ns/100ps
module test_switch_monitor_spi_core;
	localparam int WETTING_SET_PIN = 200;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  sw_r  = 8'h00;
	logic        warn_r = 1'b0;
	logic        clr_r  = 1'b1;
	logic        wd_r   = 1'b0;
	logic        cs_n, sclk, mosi, done, sdo, sdo_oe, irq_n, irq_oe;
	logic        tmp_n, tmp_oe, d0, d0_oe, d1, d1_oe, pol_up, pol_lo, hyst;
	logic [15:0] rd;
	logic [7:0]  wetting_set_pin, sense, st, v;
	wire         sdo_line;
	logic [15:0] exp_q[$];
	int          error_cnt = 0;
	int          check_count = 0;
	int          seed, nsen, nwet;

	// -------------------------------------------------
	// clock, wiring, partner
	// -------------------------------------------------
	initial
	begin
		forever #20 clk_i = ~clk_i;
	end
	// undriven data output floats, no pull on the line
	assign sdo_line = sdo_oe ? sdo : 1'bz;

	spi_master_model u_master (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk),
		.mosi_o(mosi), .miso_i(sdo_line), .rd_o(rd), .done_o(done));

	switch_monitor_spi_core #(.WET_CYC(WETTING_SET_PIN), .POLL_CYC(10), .BASE_CYC(100))
	i_dut (.clk_i(clk_i), .rst_i(rst_i), .chip_select_n_i(cs_n),
		.serial_clk_i(sclk), .serial_data_i(mosi), .serial_data_o(sdo),
		.serial_data_oe_o(sdo_oe), .switch_input_i(sw_r),
		.temp_warn_i(warn_r), .temp_clear_i(clr_r),
		.watchdog_first_timeout_i(wd_r), .irq_n_o(irq_n),
		.irq_n_oe_o(irq_oe), .overtemp_n_o(tmp_n), .overtemp_n_oe_o(tmp_oe),
		.direct_level_out0_o(d0), .direct_level_out0_oe_o(d0_oe),
		.direct_level_out1_o(d1), .direct_level_out1_oe_o(d1_oe),
		.wetting_drive_o(wetting_set_pin), .sense_connect_o(sense),
		.polarity_upper_pair_o(pol_up), .polarity_lower_pair_o(pol_lo),
		.hyst_adjust_en_o(hyst));

	// -------------------------------------------------
	// compare and helper tasks
	// -------------------------------------------------
	task automatic cmp_pin(input logic got, input logic exp, input string s);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t %s got %b exp %b", $time, s, got, exp);
		end
	endtask

	task automatic cmp_vec(input logic [15:0] got, input logic [15:0] exp,
		input string s);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	// wait n edges, then step off the edge so outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// note the status word the frame must return, then run it
	task automatic frame(input logic [15:0] wr, input logic hot);
		exp_q.push_back({st, hot, 7'h00});
		u_master.xfer(wr, 16);
		cyc(8);
	endtask

	task automatic complete_run;
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// monitor: every full 16-clock frame is matched against the oldest note
	always @(posedge clk_i)
	begin
		if (done === 1'b1)
			cmp_vec(rd, exp_q.pop_front(), "status word");
	end

	// watchdog: whole run needs roughly 54k cycles
	initial
	begin
		repeat (90000) @(posedge clk_i);
		error_cnt++;
		complete_run();
	end

	// -------------------------------------------------
	// main sequence
	// -------------------------------------------------
	initial
	begin
		seed = $urandom(32'h044d3a49);
		v = (8'($urandom()) & 8'hFC) | 8'h84;  // inputs 0/1 open at first
		st = 8'h00;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		cyc(5);
		cmp_vec(16'(sense), 16'h00FC, "reset poll");
		cmp_pin(d0_oe, 1'b0, "direct oe in scan");
		cmp_pin(sdo_oe, 1'b0, "sdo idle");
		@(posedge clk_i) sw_r <= v;
		st = v;
		cyc(6);
		cmp_pin(irq_oe, 1'b1, "irq on change");
		cmp_pin(irq_n, 1'b0, "irq pin level");
		cmp_pin(tmp_n, 1'b0, "overtemp pin level");
		// continuous wetting, normal mode, all enables
		frame(16'hFC00, 1'b0);
		cmp_pin(irq_oe, 1'b0, "irq released");
		cmp_vec(16'(wetting_set_pin), 16'(v), "continuous wetting");
		cmp_vec(16'(sense), 16'h00FF, "normal sense");
		cmp_pin(d0_oe, 1'b0, "direct oe wetting_in01_enable");
		// pulse mode, direct inputs, masks on 3..2
		frame(16'h7A0C, 1'b0);
		cmp_pin(pol_up, 1'b1, "polarity upper");
		cmp_pin(pol_lo, 1'b0, "polarity lower");
		cmp_pin(d0_oe, 1'b1, "direct oe");
		cyc(WETTING_SET_PIN);
		cmp_vec(16'(wetting_set_pin), 16'h0000, "pulse expired");
		@(posedge clk_i) sw_r <= v ^ 8'h05;
		st = v ^ 8'h04;
		cyc(6);
		cmp_pin(irq_oe, 1'b0, "masked and direct");
		cmp_vec(16'(wetting_set_pin), 16'(st & 8'hFC), "pulse on all");
		cmp_pin(d0, ~v[0], "direct copy");
		cmp_pin(d1, v[1], "direct copy 1");
		cmp_pin(d1_oe, 1'b1, "direct oe 1");
		cyc(150);
		@(posedge clk_i) sw_r <= v ^ 8'h85;
		st = st ^ 8'h80;
		cyc(6);
		cmp_pin(irq_oe, 1'b1, "unmasked change");
		cyc(150);
		cmp_vec(16'(wetting_set_pin), 16'(st & 8'hFC), "timer restarted");
		cyc(WETTING_SET_PIN);
		cmp_vec(16'(wetting_set_pin), 16'h0000, "restarted pulse ends");
		// change in mid-frame still interrupts
		fork
			frame(16'h7A0C, 1'b0);
			begin
				repeat (40) @(posedge clk_i);
				sw_r <= v ^ 8'hC5;
			end
		join
		st = st ^ 8'h40;
		cmp_pin(irq_oe, 1'b1, "irq during frame");
		// over temperature while a wetting pulse runs
		@(posedge clk_i)
		begin
			warn_r <= 1'b1;
			clr_r  <= 1'b0;
		end
		cyc(6);
		cmp_pin(tmp_oe, 1'b1, "overtemp pin");
		cmp_vec(16'(wetting_set_pin), 16'h0000, "thermal cut");
		repeat (2) frame(16'h7A0C, 1'b1);
		cmp_pin(tmp_oe, 1'b0, "overtemp released");
		@(posedge clk_i)
		begin
			warn_r <= 1'b0;
			clr_r  <= 1'b1;
		end
		cyc(6);
		frame(16'h7A0C, 1'b0);
		cmp_pin(irq_oe, 1'b0, "irq idle");
		@(posedge clk_i) wd_r <= 1'b1;
		cyc(6);
		cmp_pin(irq_oe, 1'b1, "watchdog irq");
		@(posedge clk_i) wd_r <= 1'b0;
		// short frame must be refused
		u_master.xfer(16'h7000, 8);
		cyc(8);
		cmp_pin(pol_up, 1'b1, "short frame kept");
		cmp_pin(sdo_oe, 1'b0, "sdo released");
		// every scan code: poll windows and wetting inside them
		for (int c = 0; c < 8; c++)
		begin
			frame({1'b1, 3'(c), 12'hD00}, 1'b0);
			st = v ^ 8'hC5;
			cyc(3200);
			nsen = 0;
			nwet = 0;
			repeat (3200)
			begin
				cyc(1);
				nsen += (sense === 8'hFF);
				nwet += (wetting_set_pin === st);
			end
			cmp_vec(16'(nsen), (c > 5) ? 16'h0C80 : 16'(10 << c), "poll");
			cmp_vec(16'(nwet), (c > 5) ? 16'h0C80 : 16'(10 << c), "wet");
			cmp_pin(hyst, c != 6, "hysteresis");
			cmp_pin(pol_lo, 1'b1, "polarity lower set");
		end
		complete_run();
	end
endmodule // test_switch_monitor_spi_core
